// ### hw/qei_consts.svh
`ifndef QEI_CONSTS_SVH
`define QEI_CONSTS_SVH
// How it works
// - Velocity capture runs only while position tracking is also enabled.
// - Optional swap of the two phase inputs reverses counting sense.
// - Quadrature format: direction comes from which phase edges first.
// - Step/direction format: one step per first-input edge, direction from second.
// - Capture select: count first-phase edges only, or edges of both phases.
// - First phase leading second phase increments the position.
// - Second phase leading first phase decrements the position.
// - Two edges on one phase with none between on the other flag reversal.
// - Position returns to zero on index or at maximum, per reset select.
// - Reset select 1: each index pulse clears position, range zero to N-1.
// - Counting down from zero loads the maximum; software programs N-1.
// - After an index in index mode, position is absolute from index.
// - Reset select 0: position runs zero through maximum and wraps; index ignored.
// - Velocity accumulator counts edges qualified like the position counter.
// - Period end copies accumulator to result, clears it, starts new period.
// - Timer counts down from load, flags expiry at zero, reloads, continues.
// - Four event sources: phase error, direction change, index, timer expiry.
// - Each source has mask, raw status, masked status and software clear.
// - Velocity edges pass a predivider of two to the power of the code.
// - Format bit 2: one selects step/direction, zero selects quadrature.
// - Capture bit 3: zero counts first phase, one counts both phases.
// - Bits 9, 10, 11 invert first phase, second phase and index.

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define QEI_OFS_CTL     12'h000
`define QEI_OFS_STAT    12'h004
`define QEI_OFS_POS     12'h008
`define QEI_OFS_MAXPOS  12'h00C
`define QEI_OFS_LOAD    12'h010
`define QEI_OFS_TIME    12'h014
`define QEI_OFS_COUNT   12'h018
`define QEI_OFS_SPEED   12'h01C
`define QEI_OFS_INTEN   12'h020
`define QEI_OFS_RIS     12'h024
`define QEI_OFS_ISC     12'h028

// ---------------------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------------------
`define QEI_CTL_W       13
`define QEI_CTL_ENABLE  0
`define QEI_CTL_SWAP    1
`define QEI_CTL_FORMAT  2
`define QEI_CTL_CAPTURE 3
`define QEI_CTL_RESET   4
`define QEI_CTL_VELON   5
`define QEI_CTL_DIV_LO  6
`define QEI_CTL_DIV_HI  8
`define QEI_CTL_INVERT_FIRST_PHASE    9
`define QEI_CTL_INVERT_SECOND_PHASE    10
`define QEI_CTL_INVERT_INDEX_PULSE    11

// ---------------------------------------------------------------------------
// Status and event bits
// ---------------------------------------------------------------------------
`define QEI_STAT_ERR    0
`define QEI_STAT_DIR    1
`define QEI_EV_INDEX    0
`define QEI_EV_TIMER    1
`define QEI_EV_DIR      2
`define QEI_EV_ERROR    3
`define QEI_EV_W        4

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define QEI_RST_WORD    32'h0000_0000
`define QEI_RST_CTL     13'h0000
`define QEI_RST_EV      4'h0
`define QEI_DIV_W       7
`define QEI_RST_DIV     7'h00
`endif

// ### hw/qei_pkg.sv
package qei_pkg;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] prev;
  } qei_sync_state_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [12:0] ctl;
    logic [31:0] pos;
    logic [31:0] maxpos;
    logic [31:0] load;
    logic [31:0] timer;
    logic [31:0] accum;
    logic [31:0] speed;
    logic [3:0]  inten;
    logic [3:0]  ris;
    logic        dir;
    logic        err;
    logic [6:0]  prediv;
  } qei_state_t;
endpackage

// ### hw/qei_phase_if.sv
interface qei_phase_if;
  logic quad_input_first;
  logic quad_input_second;
  logic edge_first;
  logic edge_second;
  logic index_rise;
  logic invert_first_phase;
  logic invert_second_phase;
  logic invert_index_pulse;
  logic swap_phases;

  modport src (input  invert_first_phase, invert_second_phase, invert_index_pulse,
               input  swap_phases,
               output quad_input_first, quad_input_second, edge_first, edge_second,
               output index_rise);
  modport snk (output invert_first_phase, invert_second_phase, invert_index_pulse,
               output swap_phases,
               input  quad_input_first, quad_input_second, edge_first, edge_second,
               input  index_rise);
endinterface

// ### hw/qei_input_sync.sv
`include "qei_consts.svh"
module qei_input_sync
  import qei_pkg::*;
(
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rstn,
  // Encoder pins
  input  wire logic   i_phase_first,
  input  wire logic   i_phase_second,
  input  wire logic   i_index,
  // Decoded phases
  qei_phase_if.src    ph
);
  import qei_pkg::*;

  qei_sync_state_t q;
  qei_sync_state_t d;
  logic [2:0]      cond;

  // ---------------------------------------------------------------------------
  // Synchroniser, inversion and swap
  // ---------------------------------------------------------------------------
  // Inversion and swap act after the second flop so the first flop stays private.
  always_comb begin
    cond = {q.s2[2] ^ ph.invert_index_pulse,
            q.s2[1] ^ ph.invert_second_phase,
            q.s2[0] ^ ph.invert_first_phase};
    if (ph.swap_phases) begin
      cond[1:0] = {cond[0], cond[1]};
    end
    d      = q;
    d.s1   = {i_index, i_phase_second, i_phase_first};
    d.s2   = q.s1;
    d.prev = cond;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ph.quad_input_first  = cond[0];
  assign ph.quad_input_second = cond[1];
  assign ph.edge_first        = cond[0] ^ q.prev[0];
  assign ph.edge_second       = cond[1] ^ q.prev[1];
  assign ph.index_rise        = cond[2] & ~q.prev[2];
endmodule

// ### hw/qei_top.sv
// The address map and the APB interface to the registers were left to the implementer.
`include "qei_consts.svh"
module qei_top
  import qei_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Encoder pins
  input  wire logic        i_quad_input_first,
  input  wire logic        i_quad_input_second,
  input  wire logic        i_index_input
);
  import qei_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] step_pos(input logic [31:0] pos,
                                           input logic [31:0] maxv,
                                           input logic        down);
    logic [31:0] r;
    r = pos;
    if (down) begin
      r = (pos == `QEI_RST_WORD) ? maxv : pos - 32'h0000_0001;
    end else begin
      r = (pos >= maxv) ? `QEI_RST_WORD : pos + 32'h0000_0001;
    end
    return r;
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  qei_state_t q;
  qei_state_t d;
  qei_phase_if ph();

  logic        enable;
  logic        vel_on;
  logic        step_fmt;
  logic        both_caps;
  logic        ph_err;
  logic        count_ev;
  logic        down;
  logic        dir_flip;
  logic        vel_ev;
  logic [6:0]  div_mask;
  logic        expire;
  logic        wr;
  logic        setup;
  logic [3:0]  ev;
  logic [31:0] rdata;
  logic        hit;

  // ---------------------------------------------------------------------------
  // Input conditioning
  // ---------------------------------------------------------------------------
  assign ph.invert_first_phase  = q.ctl[`QEI_CTL_INVERT_FIRST_PHASE];
  assign ph.invert_second_phase = q.ctl[`QEI_CTL_INVERT_SECOND_PHASE];
  assign ph.invert_index_pulse  = q.ctl[`QEI_CTL_INVERT_INDEX_PULSE];
  assign ph.swap_phases         = q.ctl[`QEI_CTL_SWAP];

  qei_input_sync u_sync (
    .i_clk          (i_clk),
    .i_rstn         (i_rstn),
    .i_phase_first  (i_quad_input_first),
    .i_phase_second (i_quad_input_second),
    .i_index        (i_index_input),
    .ph             (ph)
  );

  // ---------------------------------------------------------------------------
  // Edge decoding
  // ---------------------------------------------------------------------------
  // In quadrature a simultaneous change of both phases cannot be ordered, so it moves nothing.
  always_comb begin
    enable    = q.ctl[`QEI_CTL_ENABLE];
    vel_on    = enable & q.ctl[`QEI_CTL_VELON];
    step_fmt  = q.ctl[`QEI_CTL_FORMAT];
    both_caps = q.ctl[`QEI_CTL_CAPTURE] & ~step_fmt;
    ph_err    = ~step_fmt & ph.edge_first & ph.edge_second;
    down      = q.dir;
    count_ev  = 1'b0;
    if (step_fmt) begin
      count_ev = ph.edge_first;
      down     = ph.quad_input_second;
    end else if (!ph_err) begin
      if (ph.edge_first) begin
        down     = (ph.quad_input_first == ph.quad_input_second);
        count_ev = 1'b1;
      end else if (ph.edge_second) begin
        down     = (ph.quad_input_first != ph.quad_input_second);
        count_ev = both_caps;
      end
    end
    // In quadrature two edges on one phase with none between reverse the sense.
    dir_flip = enable & (ph.edge_first | ph.edge_second) & ~ph_err
               & (down != q.dir);
  end

  // ---------------------------------------------------------------------------
  // Velocity predivider and timer
  // ---------------------------------------------------------------------------
  always_comb begin
    div_mask = `QEI_DIV_W'((8'h01 << q.ctl[`QEI_CTL_DIV_HI:`QEI_CTL_DIV_LO]) - 8'h01);
    vel_ev   = vel_on & count_ev & ((q.prediv & div_mask) == div_mask);
    expire   = vel_on & (q.timer == `QEI_RST_WORD);
  end

  // ---------------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------------
  always_comb begin
    setup = i_psel & ~i_penable;
    wr    = i_psel & i_penable & q.pready & i_pwrite;
    hit   = 1'b1;
    rdata = `QEI_RST_WORD;
    unique case (1'b1)
      addr_is(i_paddr, `QEI_OFS_CTL):    rdata = 32'(q.ctl);
      addr_is(i_paddr, `QEI_OFS_STAT):   rdata = 32'({q.dir, q.err});
      addr_is(i_paddr, `QEI_OFS_POS):    rdata = q.pos;
      addr_is(i_paddr, `QEI_OFS_MAXPOS): rdata = q.maxpos;
      addr_is(i_paddr, `QEI_OFS_LOAD):   rdata = q.load;
      addr_is(i_paddr, `QEI_OFS_TIME):   rdata = q.timer;
      addr_is(i_paddr, `QEI_OFS_COUNT):  rdata = q.accum;
      addr_is(i_paddr, `QEI_OFS_SPEED):  rdata = q.speed;
      addr_is(i_paddr, `QEI_OFS_INTEN):  rdata = 32'(q.inten);
      addr_is(i_paddr, `QEI_OFS_RIS):    rdata = 32'(q.ris);
      addr_is(i_paddr, `QEI_OFS_ISC):    rdata = 32'(q.ris & q.inten);
      default:                           hit   = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    d = q;
    // One wait state: pready rises in the second access cycle, data with it.
    d.pready  = i_psel & i_penable & ~q.pready;
    d.pslverr = i_psel & i_penable & ~q.pready & ~hit;
    // Read data stands only with pready, so an idle bus always shows zero.
    if (i_psel & i_penable & ~q.pready) begin
      d.prdata = (hit & ~i_pwrite) ? rdata : `QEI_RST_WORD;
    end else begin
      d.prdata = `QEI_RST_WORD;
    end
    if (setup) begin
      d.prdata = `QEI_RST_WORD;
    end

    // Software writes take effect at the edge that completes the transfer.
    if (wr & hit) begin
      unique case (1'b1)
        addr_is(i_paddr, `QEI_OFS_CTL):    d.ctl    = i_pwdata[`QEI_CTL_W-1:0];
        addr_is(i_paddr, `QEI_OFS_POS):    d.pos    = i_pwdata;
        addr_is(i_paddr, `QEI_OFS_MAXPOS): d.maxpos = i_pwdata;
        addr_is(i_paddr, `QEI_OFS_LOAD):   d.load   = i_pwdata;
        addr_is(i_paddr, `QEI_OFS_INTEN):  d.inten  = i_pwdata[`QEI_EV_W-1:0];
        addr_is(i_paddr, `QEI_OFS_ISC):    d.ris    = q.ris & ~i_pwdata[`QEI_EV_W-1:0];
        default:                           d.ctl    = q.ctl;
      endcase
    end

    // Position counter.
    if (enable) begin
      if (count_ev) begin
        d.pos = step_pos(q.pos, q.maxpos, down);
      end
      if (q.ctl[`QEI_CTL_RESET] & ph.index_rise) begin
        d.pos = `QEI_RST_WORD;
      end
      if (ph.edge_first | ph.edge_second) begin
        d.dir = down;
      end
      d.err = ph_err;
    end

    // Velocity capture; timer stops and is reloaded while capture is off.
    if (vel_on) begin
      if (count_ev) begin
        d.prediv = q.prediv + `QEI_DIV_W'(1);
      end
      if (expire) begin
        d.speed = q.accum + (vel_ev ? 32'h0000_0001 : `QEI_RST_WORD);
        d.accum = `QEI_RST_WORD;
        d.timer = q.load;
      end else begin
        d.timer = q.timer - 32'h0000_0001;
        if (vel_ev) begin
          d.accum = q.accum + 32'h0000_0001;
        end
      end
    end else begin
      d.timer  = q.load;
      d.prediv = `QEI_RST_DIV;
    end

    // Raw status: a new event wins over a clear in the same cycle.
    ev = `QEI_RST_EV;
    ev[`QEI_EV_INDEX] = enable & ph.index_rise;
    ev[`QEI_EV_TIMER] = expire;
    ev[`QEI_EV_DIR]   = dir_flip;
    ev[`QEI_EV_ERROR] = enable & ph_err;
    d.ris = d.ris | ev;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_prdata  = q.prdata;
  assign o_pready  = q.pready;
  assign o_pslverr = q.pslverr;
endmodule

// ### sim/qei_top_asserts.sv
module qei_top_asserts (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rstn,
  // Bus and pins
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_quad_input_first,
  input wire logic        i_quad_input_second,
  input wire logic        i_index_input
);
  // ----------------------------------------
  // Bus answer checks.
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence acc_s;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence bad_s;
    acc_s ##0 (i_paddr > 12'h028);
  endsequence
  ready_wait_a: assert property (acc_s |=> o_pready)
    else $error("ready late");
  ready_pulse_a: assert property (o_pready |=> !o_pready [*2])
    else $error("ready too long");
  ready_cause_a: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("ready unasked");
  data_idle_a: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("data not idle");
  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("error alone");
  bad_addr_a: assert property (bad_s |=> o_pslverr)
    else $error("no error");
  bad_read_a: assert property (bad_s ##0 !i_pwrite |=> o_prdata == 32'h0000_0000)
    else $error("bad read data");
  good_addr_a: assert property (acc_s ##0 (i_paddr <= 12'h028 && i_paddr[1:0] == 2'b00)
    |=> !o_pslverr)
    else $error("false error");
  setup_quiet_a: assert property (i_psel && !i_penable |-> !o_pready)
    else $error("ready in setup");
endmodule

bind qei_top qei_top_asserts i_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_quad_input_first(i_quad_input_first),
  .i_quad_input_second(i_quad_input_second), .i_index_input(i_index_input)
);

// ### sim/qei_encoder_model.sv
module qei_encoder_model (
  // Clock
  input  wire logic i_clk,
  // Encoder pins
  output logic      o_first,
  output logic      o_second,
  output logic      o_index
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Pin drivers.
  // ----------------------------------------
  logic [1:0] st = 2'd0;
  initial begin
    o_first = 1'b0;
    o_second = 1'b0;
    o_index = 1'b0;
  end
  // Levels hold four clocks, the fastest rate the decoder is meant to follow.
  task automatic pins(input logic f, input logic s);
    @(posedge i_clk);
    o_first <= f;
    o_second <= s;
    repeat (3) @(posedge i_clk);
  endtask
  // Forward order keeps the first phase a quarter cycle ahead.
  task automatic quad(input logic up, input logic [31:0] n);
    repeat (n) begin
      st = up ? st + 2'd1 : st - 2'd1;
      pins(st[1] ^ st[0], st[1]);
    end
  endtask
  task automatic idx();
    @(posedge i_clk);
    o_index <= 1'b1;
    repeat (4) @(posedge i_clk);
    o_index <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask
endmodule

// ### sim/test_quadrature_encoder_interface.sv
module test_quadrature_encoder_interface;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bench state.
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_first;
  logic        pin_second;
  logic        pin_index;
  logic [31:0] q;
  logic        qerr;
  logic [31:0] seed = 32'hB731;
  logic [31:0] n;
  logic [31:0] ex;
  logic [11:0] ro [5] = '{12'h004, 12'h014, 12'h018, 12'h01C, 12'h024};
  int          n_errors = 0;
  int          num_checks = 0;

  always #10 clk = ~clk;

  qei_top i_dut (
    .i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_quad_input_first(pin_first), .i_quad_input_second(pin_second),
    .i_index_input(pin_index)
  );
  qei_encoder_model i_enc (.i_clk(clk), .o_first(pin_first), .o_second(pin_second),
    .o_index(pin_index));

  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] nxt(input logic [31:0] p, input logic [31:0] m);
    return (p >= m) ? 32'h0 : p + 32'h1;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // The request is held until ready is seen high at a falling edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready is looked at mid-cycle, where it is settled, before the edge that takes it.
    do begin
      @(negedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t bus hang", $time);
    end
    q = prdata;
    qerr = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic wait_tmr();
    int t;
    t = 0;
    do begin
      apb(1'b0, 12'h024, 32'h0);
      t++;
    end while (q[1] !== 1'b1 && t < 400);
    chk({31'h0, q[1]}, 32'h1);
  endtask
  task automatic close_out();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    n_errors++;
    close_out();
  end

  // ----------------------------------------
  // Tests.
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a <= 40; a += 4) rd(12'(a), '1, 32'h0);
    foreach (ro[i]) begin
      wr(ro[i], '1);
      rd(ro[i], '1, 32'h0);
    end
    apb(1'b0, 12'h030, 32'h0);
    chk({qerr, q}, 33'h1_0000_0000);
    i_enc.quad(1'b1, 32'd4);
    rd(12'h008, '1, 32'h0);
    $display("Test reset done");
    wr(12'h000, 32'h18);
    wr(12'h00C, 32'hF9F);
    wr(12'h000, 32'h19);
    n = (rnd() % 8 + 1) * 4;
    i_enc.quad(1'b1, n);
    rd(12'h008, '1, n);
    i_enc.quad(1'b0, n + 8);
    rd(12'h008, '1, 32'hF98);
    rd(12'h024, 32'h4, 32'h4);
    i_enc.idx();
    rd(12'h008, '1, 32'h0);
    i_enc.quad(1'b1, 32'd4);
    rd(12'h008, '1, 32'h4);
    rd(12'h028, '1, 32'h0);
    wr(12'h020, 32'hF);
    rd(12'h028, 32'hF, 32'h5);
    wr(12'h028, 32'hF);
    rd(12'h024, 32'hF, 32'h0);
    $display("Test index done");
    wr(12'h000, 32'h01);
    wr(12'h008, 32'h0);
    wr(12'h00C, 32'h9);
    n = rnd() % 6 + 3;
    i_enc.quad(1'b1, 4 * n);
    ex = 0;
    repeat (2 * n) ex = nxt(ex, 32'h9);
    rd(12'h008, '1, ex);
    i_enc.idx();
    rd(12'h008, '1, ex);
    wr(12'h000, 32'h0B);
    wr(12'h008, 32'h5);
    i_enc.quad(1'b1, 32'd4);
    rd(12'h008, '1, 32'h1);
    $display("Test modes done");
    wr(12'h000, 32'h05);
    wr(12'h008, 32'h0);
    for (int i = 1; i <= 6; i++) i_enc.pins(i[0], 1'b0);
    for (int i = 0; i <= 4; i++) i_enc.pins(i[0], 1'b1);
    i_enc.pins(1'b0, 1'b0);
    rd(12'h008, '1, 32'h2);
    wr(12'h000, 32'h01);
    wr(12'h028, 32'hF);
    i_enc.pins(1'b1, 1'b1);
    i_enc.pins(1'b0, 1'b0);
    rd(12'h024, 32'h8, 32'h8);
    rd(12'h008, '1, 32'h2);
    $display("Test step and error done");
    wr(12'h010, 32'h77);
    wr(12'h000, 32'h20);
    rd(12'h014, '1, 32'h77);
    wr(12'h010, 32'h3E8);
    for (int c = 0; c < 8; c++) begin
      wr(12'h000, 32'h09);
      wr(12'h000, 32'h29 | (c << 6));
      wr(12'h028, 32'hF);
      wait_tmr();
      wr(12'h028, 32'hF);
      i_enc.quad(1'b1, 32'd128);
      wait_tmr();
      rd(12'h01C, '1, 32'(128 >> c));
    end
    $display("Test velocity done");
    close_out();
  end
endmodule
